/* File: verilog/pulse_counter.sv */
// four signed 32-bit pulse counters with APB register access
// assumes count, direction, gate and latch pins synchronous to clk_sys_i
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module pulse_counter
  import pulse_counter_pkg::*;
#(
  parameter logic [FILT_W-1:0] MIN_CYC_1K = FILT_W'(CYC_1K),
  parameter logic [FILT_W-1:0] MIN_CYC_2K = FILT_W'(CYC_2K)
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire pins_type pins_i,
  output logic [NUM_CH-1:0] irq_o
);

  ctrl_type ctrl_q [NUM_CH];
  logic signed [31:0] value_q [NUM_CH];
  logic signed [31:0] load_q [NUM_CH];
  logic signed [31:0] end_q [NUM_CH];
  logic signed [31:0] nxt [NUM_CH];
  logic signed [31:0] latch_q;
  logic [NUM_CH-1:0] ovf_q, unf_q, closed_q, started_q, sw_prev_q, irq_q;
  logic [NUM_CH-1:0] gate_raw, open, step, trig, reload, ld_cmd, clr_req;
  logic [NUM_CH-1:0] set_ovf, set_unf, auto_close, end_evt;
  logic [NUM_PINS-1:0] clean, prev_q, rise;
  logic [FILT_W-1:0] thr [NUM_PINS];
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic wr_en, rd_setup;

  function automatic logic [FILT_W-1:0] fsel_cycles(input logic [2:0] sel);
    logic [FILT_W-1:0] r;
    r = FILT_W'(CYC_60K);
    case (sel)
      FSEL_1K: r = MIN_CYC_1K;
      FSEL_2K: r = MIN_CYC_2K;
      FSEL_5K: r = FILT_W'(CYC_5K);
      FSEL_10K: r = FILT_W'(CYC_10K);
      FSEL_30K: r = FILT_W'(CYC_30K);
      default: r = FILT_W'(CYC_60K);
    endcase
    return r;
  endfunction

  // channel register space holds four channels below REG_LATCH
  function automatic logic ch_hit(input logic [7:0] a, input int c, input logic [4:0] r);
    return (a[7] == 1'b0) && (a[6:5] == c[1:0]) && (a[4:0] == r);
  endfunction

  // pin qualification: per-channel step for count/dir, channel 3 steps for gate and latch
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      thr[c] = fsel_cycles(ctrl_q[c].count_fsel);
      thr[c + NUM_CH] = fsel_cycles(ctrl_q[c].count_fsel);
    end
    thr[8] = fsel_cycles(ctrl_q[HARDWARE_GATE_CH].count_fsel);
    thr[9] = fsel_cycles(ctrl_q[HARDWARE_GATE_CH].latch_fsel);
  end

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_qual
    pulse_qualifier u_qual (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .raw_i(pins_i[i]),
      .min_cyc_i(thr[i]),
      .clean_o(clean[i])
    );
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= '0;
      sw_prev_q <= '0;
    end else begin
      prev_q <= clean;
      for (int c = 0; c < NUM_CH; c++) begin
        sw_prev_q[c] <= ctrl_q[c].software_gate;
      end
    end
  end

  assign rise = clean & ~prev_q;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_setup = psel_i && !penable_i;

  // gate evaluation and restart triggers
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      ld_cmd[c] = wr_en && ch_hit(paddr_i, c, REG_CTRL) && pwdata_i[CTRL_LOAD_BIT];
      clr_req[c] = wr_en && ch_hit(paddr_i, c, REG_STATUS) && pwdata_i[ST_CLEAR_BIT];
      if (c == HARDWARE_GATE_CH && ctrl_q[c].hardware_gate_en) begin
        gate_raw[c] = ctrl_q[c].software_gate && clean[8];
        trig[c] = rise[8] && ctrl_q[c].software_gate;
      end else begin
        gate_raw[c] = ctrl_q[c].software_gate;
        trig[c] = ctrl_q[c].software_gate && !sw_prev_q[c];
      end
      open[c] = gate_raw[c] && !closed_q[c];
      step[c] = open[c] && rise[c];
      // abort reloads; after auto close with a main direction the load value is used too
      reload[c] = ctrl_q[c].gate_abort || !started_q[c]
        || (closed_q[c] && ctrl_q[c].main_dir != DIR_NONE);
    end
  end

  // next count value for one qualified pulse
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      logic up;
      logic once;
      logic per;
      up = clean[c + NUM_CH];
      once = ctrl_q[c].mode == MODE_ONCE;
      per = ctrl_q[c].mode == MODE_PERIODIC;
      nxt[c] = up ? value_q[c] + 32'sd1 : value_q[c] - 32'sd1;
      set_ovf[c] = 1'b0;
      set_unf[c] = 1'b0;
      auto_close[c] = 1'b0;
      end_evt[c] = 1'b0;
      if (!step[c]) begin
        nxt[c] = value_q[c];
      end else if (ctrl_q[c].main_dir == DIR_NONE || !(once || per)) begin
        if (up && value_q[c] == CNT_MAX) begin
          set_ovf[c] = 1'b1;
          nxt[c] = per ? load_q[c] : CNT_MIN;
          auto_close[c] = once;
        end else if (!up && value_q[c] == CNT_MIN) begin
          set_unf[c] = 1'b1;
          nxt[c] = per ? load_q[c] : CNT_MAX;
          auto_close[c] = once;
        end
      end else if (ctrl_q[c].main_dir == DIR_FWD && up && value_q[c] == end_q[c] - 32'sd1) begin
        nxt[c] = load_q[c];
        end_evt[c] = 1'b1;
        auto_close[c] = once;
      end else if (ctrl_q[c].main_dir == DIR_BWD && !up
                   && value_q[c] == end_q[c] + 32'sd1) begin
        nxt[c] = load_q[c];
        end_evt[c] = 1'b1;
        auto_close[c] = once;
      end
    end
  end

  // software-written configuration
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        ctrl_q[c] <= CTRL_RESET;
        load_q[c] <= '0;
        end_q[c] <= '0;
      end
    end else if (wr_en) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (ch_hit(paddr_i, c, REG_CTRL)) begin
          ctrl_q[c] <= ctrl_type'(pwdata_i[CTRL_W-1:0]);
        end
        if (ch_hit(paddr_i, c, REG_LOAD)) begin
          load_q[c] <= pwdata_i;
        end
        if (ch_hit(paddr_i, c, REG_END)) begin
          end_q[c] <= pwdata_i;
        end
      end
    end
  end

  // count value
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        value_q[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (ld_cmd[c]) begin
          value_q[c] <= load_q[c];
        end else if (trig[c]) begin
          if (reload[c]) begin
            value_q[c] <= load_q[c];
          end
        end else begin
          value_q[c] <= nxt[c];
        end
      end
    end
  end

  // gate state: auto close and first start
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      closed_q <= '0;
      started_q <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (trig[c]) begin
          closed_q[c] <= 1'b0;
          started_q[c] <= 1'b1;
        end else if (auto_close[c]) begin
          closed_q[c] <= 1'b1;
        end
        if (ld_cmd[c]) begin
          started_q[c] <= 1'b1;
        end
      end
    end
  end

  // sticky flags, a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovf_q <= '0;
      unf_q <= '0;
    end else begin
      ovf_q <= set_ovf | (ovf_q & ~clr_req);
      unf_q <= set_unf | (unf_q & ~clr_req);
    end
  end

  // one-cycle event pulse per channel when enabled, none for an end event that auto closes
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        irq_q[c] <= (set_ovf[c] && ctrl_q[c].ovf_irq_en)
          || (set_unf[c] && ctrl_q[c].unf_irq_en)
          || (end_evt[c] && !auto_close[c] && ctrl_q[c].end_irq_en);
      end
    end
  end

  // latch of counter three on a qualified rising edge while counting
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_q <= '0;
    end else if (rise[9] && open[HARDWARE_GATE_CH]) begin
      latch_q <= value_q[HARDWARE_GATE_CH];
    end
  end

  // read data is captured in the setup cycle and shown in the access cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (rd_setup) begin
      prdata_q <= '0;
      pslverr_q <= 1'b1;
      if (paddr_i == REG_LATCH) begin
        prdata_q <= latch_q;
        pslverr_q <= 1'b0;
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (ch_hit(paddr_i, c, REG_CTRL)) begin
          prdata_q <= {16'h0000, ctrl_q[c]};
          pslverr_q <= 1'b0;
        end else if (ch_hit(paddr_i, c, REG_LOAD)) begin
          prdata_q <= load_q[c];
          pslverr_q <= 1'b0;
        end else if (ch_hit(paddr_i, c, REG_END)) begin
          prdata_q <= end_q[c];
          pslverr_q <= 1'b0;
        end else if (ch_hit(paddr_i, c, REG_VALUE)) begin
          prdata_q <= value_q[c];
          pslverr_q <= 1'b0;
        end else if (ch_hit(paddr_i, c, REG_STATUS)) begin
          prdata_q <= {28'h0000000, closed_q[c], open[c], unf_q[c], ovf_q[c]};
          pslverr_q <= 1'b0;
        end
      end
    end
  end

  assign prdata_o = prdata_q;
  assign pslverr_o = pslverr_q && psel_i && penable_i;
  assign pready_o = 1'b1;
  assign irq_o = irq_q;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_wrap_up_cont: assert property (
    step[0] && ctrl_q[0].mode == MODE_CONT && clean[4] && value_q[0] == CNT_MAX
    && !ld_cmd[0] && !trig[0] |=> value_q[0] == CNT_MIN && ovf_q[0])
    else $error("continuous up wrap failed");

  a_wrap_down_cont: assert property (
    step[0] && ctrl_q[0].mode == MODE_CONT && !clean[4] && value_q[0] == CNT_MIN
    && !ld_cmd[0] && !trig[0] |=> value_q[0] == CNT_MAX && unf_q[0])
    else $error("continuous down wrap failed");

  a_ovf_sticky_hold: assert property (
    ovf_q[0] && !clr_req[0] |=> ovf_q[0])
    else $error("overflow flag dropped without clear");

  a_once_wrap_close: assert property (
    step[1] && ctrl_q[1].mode == MODE_ONCE && ctrl_q[1].main_dir == DIR_NONE && clean[5]
    && value_q[1] == CNT_MAX && !ld_cmd[1] && !trig[1]
    |=> closed_q[1] && value_q[1] == CNT_MIN && !open[1])
    else $error("count once did not close at limit");

  a_once_fwd_end: assert property (
    step[2] && ctrl_q[2].mode == MODE_ONCE && ctrl_q[2].main_dir == DIR_FWD && clean[6]
    && value_q[2] == end_q[2] - 32'sd1 && !ld_cmd[2] && !trig[2]
    |=> value_q[2] == $past(load_q[2]) && closed_q[2])
    else $error("count once forward end not handled");

  a_per_bwd_end: assert property (
    step[2] && ctrl_q[2].mode == MODE_PERIODIC && ctrl_q[2].main_dir == DIR_BWD && !clean[6]
    && value_q[2] == end_q[2] + 32'sd1 && !ld_cmd[2] && !trig[2]
    |=> value_q[2] == $past(load_q[2]) && !closed_q[2])
    else $error("periodic backward reload failed");

  a_software_gate_only: assert property (
    !ctrl_q[1].software_gate && !ld_cmd[1] |=> $stable(value_q[1]))
    else $error("counter moved with software gate closed");

  a_hardware_gate_hold: assert property (
    ctrl_q[3].hardware_gate_en && !clean[8] && !ld_cmd[3] && !trig[3] |=> $stable(value_q[3]))
    else $error("counter three moved with hardware gate low");

  a_abort_reload: assert property (
    trig[0] && ctrl_q[0].gate_abort && !ld_cmd[0] |=> value_q[0] == $past(load_q[0]))
    else $error("abort gate did not restart from load value");

  a_intr_continue: assert property (
    trig[1] && !ctrl_q[1].gate_abort && started_q[1] && ctrl_q[1].main_dir == DIR_NONE
    && !ld_cmd[1] |=> $stable(value_q[1]))
    else $error("interrupt gate did not continue from last value");

  c_ovf_event: cover property (set_ovf[0] ##1 ovf_q[0]);
  c_once_close: cover property (auto_close[3] ##[1:50] trig[3]);
  c_periodic_reload: cover property (end_evt[2] && ctrl_q[2].mode == MODE_PERIODIC);
  c_latch_take: cover property (rise[9] && open[HARDWARE_GATE_CH]);

endmodule

/* File: verilog/pulse_counter_pkg.sv */
// constants, field layouts and carrier types for the four-channel pulse counter
// assumes a 50 MHz system clock and an APB bus with 32-bit data
package pulse_counter_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned HARDWARE_GATE_CH = 3;
  localparam int unsigned NUM_PINS = 10;
  localparam int unsigned FILT_W = 15;

  // shortest accepted pulse for each frequency step, in ns
  localparam int unsigned T_1K_NS = 400000;
  localparam int unsigned T_2K_NS = 200000;
  localparam int unsigned T_5K_NS = 80000;
  localparam int unsigned T_10K_NS = 40000;
  localparam int unsigned T_30K_NS = 13000;
  localparam int unsigned T_60K_NS = 6700;
  localparam int unsigned CYC_1K = (T_1K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_2K = (T_2K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_5K = (T_5K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_10K = (T_10K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_30K = (T_30K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_60K = (T_60K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // frequency step codes
  localparam logic [2:0] FSEL_1K = 3'h0;
  localparam logic [2:0] FSEL_2K = 3'h1;
  localparam logic [2:0] FSEL_5K = 3'h2;
  localparam logic [2:0] FSEL_10K = 3'h3;
  localparam logic [2:0] FSEL_30K = 3'h4;
  localparam logic [2:0] FSEL_60K = 3'h5;

  // operating modes and main counting directions
  localparam logic [1:0] MODE_CONT = 2'h0;
  localparam logic [1:0] MODE_ONCE = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] DIR_NONE = 2'h0;
  localparam logic [1:0] DIR_FWD = 2'h1;
  localparam logic [1:0] DIR_BWD = 2'h2;

  localparam logic signed [31:0] CNT_MAX = 32'sh7fffffff;
  localparam logic signed [31:0] CNT_MIN = 32'sh80000000;

  // register map: channel c at c * CH_STRIDE, latch word above all channels
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_LOAD = 5'h04;
  localparam logic [4:0] REG_END = 5'h08;
  localparam logic [4:0] REG_VALUE = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [7:0] REG_LATCH = 8'h80;

  localparam int unsigned CTRL_W = 16;
  localparam int unsigned CTRL_LOAD_BIT = 16;
  localparam int unsigned ST_OVF_BIT = 0;
  localparam int unsigned ST_UNF_BIT = 1;
  localparam int unsigned ST_OPEN_BIT = 2;
  localparam int unsigned ST_CLOSED_BIT = 3;
  localparam int unsigned ST_CLEAR_BIT = 8;

  // control word, bit 0 is mode[0]
  typedef struct packed {
    logic end_irq_en;
    logic unf_irq_en;
    logic ovf_irq_en;
    logic [2:0] latch_fsel;
    logic [2:0] count_fsel;
    logic hardware_gate_en;
    logic software_gate;
    logic gate_abort;
    logic [1:0] main_dir;
    logic [1:0] mode;
  } ctrl_type;

  localparam ctrl_type CTRL_RESET = '{end_irq_en: 1'b0, unf_irq_en: 1'b0, ovf_irq_en: 1'b0,
    latch_fsel: FSEL_10K, count_fsel: FSEL_60K, hardware_gate_en: 1'b0, software_gate: 1'b0,
    gate_abort: 1'b0, main_dir: DIR_NONE, mode: MODE_CONT};

  // external pins, all synchronous to the system clock
  typedef struct packed {
    logic latch;
    logic hardware_gate;
    logic [3:0] dir;
    logic [3:0] pulse;
  } pins_type;

endpackage

/* File: verilog/pulse_qualifier.sv */
// minimum-width qualifier for one input pin
// assumes the pin is already synchronous to clk_sys_i
`timescale 1ns/1ps
module pulse_qualifier
  import pulse_counter_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic raw_i,
  input wire logic [FILT_W-1:0] min_cyc_i,
  output logic clean_o
);

  logic [FILT_W-1:0] run_q;
  logic clean_q;

  // a new level is taken only after it has stood for min_cyc_i cycles
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= '0;
      clean_q <= 1'b0;
    end else if (raw_i == clean_q) begin
      run_q <= '0;
    end else if (run_q >= min_cyc_i - FILT_W'(1)) begin
      run_q <= '0;
      clean_q <= raw_i;
    end else begin
      run_q <= run_q + FILT_W'(1);
    end
  end

  assign clean_o = clean_q;

  a_qual_width: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (clean_q != raw_i) && (run_q == min_cyc_i - FILT_W'(1)) |=> clean_q == $past(raw_i))
    else $error("qualified level did not follow a pulse of full width");

endmodule

/* File: tb/pulse_source.sv */
// count, direction, gate and latch sources standing in front of the pulse counter
// assumes the bench calls its tasks; levels change only just after a rising clock edge
`timescale 1ns/1ps
module pulse_source
  import pulse_counter_pkg::*;
(
  input wire logic clk_sys_i,
  output pins_type pins_o
);
  initial pins_o = '0;

  // hold pin idx at level v for w+1 sampled edges; also gives the gate edge
  task automatic drive(input int idx, input logic v, input int w);
    @(posedge clk_sys_i);
    pins_o[idx] <= v;
    repeat (w) @(posedge clk_sys_i);
  endtask

  // direction settles before the pulse rises; pulse is high for exactly w edges
  task automatic pulse(input int ch, input logic up, input int w, input int n);
    drive(4 + ch, up, n + 2);
    drive(ch, 1'b1, w - 1);
    drive(ch, 1'b0, n + 4);
  endtask
endmodule

/* File: tb/pulse_counter_tb.sv */
// self-checking bench for the pulse counter: apb tasks plus pin stimulus
// assumes pulse_source drives the pins and the 1 kHz filter is shortened to N cycles
`timescale 1ns/1ps
module pulse_counter_tb;
  import pulse_counter_pkg::*;
  localparam int N = 40;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic [31:0] rd;
  logic pready_o;
  logic pslverr_o;
  logic err;
  pins_type pins_i;
  logic [NUM_CH-1:0] irq_o;
  int fail_count = 0;
  int comparisons = 0;
  int irq_cnt = 0;
  int irq_end_cnt = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  pulse_counter #(.MIN_CYC_1K(15'(N)), .MIN_CYC_2K(15'(20))) DUT (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .pins_i(pins_i),
    .irq_o(irq_o)
  );

  pulse_source src (.clk_sys_i(clk_sys_i), .pins_o(pins_i));

  always @(posedge clk_sys_i) begin
    if (irq_o[0] === 1'b1) irq_cnt++;
    if (irq_o[2] === 1'b1) irq_end_cnt++;
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  function automatic logic [7:0] ad(input int ch, input logic [4:0] off);
    return 8'(ch) * CH_STRIDE + 8'(off);
  endfunction

  function automatic logic [31:0] cw(input logic [1:0] m, input logic [1:0] d, input logic ab,
    input logic sw, input logic hw, input logic [2:0] fs);
    ctrl_type c;
    c = CTRL_RESET;
    c.mode = m;
    c.main_dir = d;
    c.gate_abort = ab;
    c.software_gate = sw;
    c.hardware_gate_en = hw;
    c.count_fsel = fs;
    c.latch_fsel = FSEL_1K;
    c.ovf_irq_en = 1'b1;
    c.unf_irq_en = 1'b1;
    return {16'h0000, c};
  endfunction

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic value_is(input int ch, input logic [31:0] exp);
    apb(1'b0, ad(ch, REG_VALUE), 32'h0);
    check_word(rd, exp, "counter value");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    logic [2:0] fs_tab [2];
    int n_tab [2];
    logic up;
    logic [1:0] m;
    fs_tab = '{FSEL_1K, FSEL_60K};
    n_tab = '{N, 335};
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    apb(1'b0, ad(0, REG_CTRL), 32'h0);
    check_word(rd, 32'h00000e80, "ctrl reset");
    check_bit(pready_o, 1'b1, "ready idle");
    value_is(0, 32'h0);
    check_bit(err, 1'b0, "mapped read error");
    apb(1'b1, 8'h84, 32'h1);
    check_bit(err, 1'b1, "unmapped error");
    $display("test reset done");
    // a pulse one cycle short of the step is dropped, the exact width counts
    foreach (fs_tab[i]) begin
      apb(1'b1, ad(0, REG_LOAD), 32'h0);
      apb(1'b1, ad(0, REG_CTRL), cw(MODE_CONT, DIR_NONE, 1'b1, 1'b1, 1'b0, fs_tab[i]));
      src.pulse(0, 1'b1, n_tab[i] - 1, n_tab[i]);
      src.pulse(0, 1'b1, n_tab[i], n_tab[i]);
      value_is(0, 32'h1);
      apb(1'b1, ad(0, REG_CTRL), 32'h0);
    end
    $display("test filter done");
    apb(1'b1, ad(0, REG_LOAD), CNT_MAX - 1);
    apb(1'b1, ad(0, REG_CTRL), cw(MODE_CONT, DIR_NONE, 1'b1, 1'b1, 1'b0, FSEL_1K));
    irq_cnt = 0;
    src.pulse(0, 1'b1, N, N);
    value_is(0, CNT_MAX);
    src.pulse(0, 1'b1, N, N);
    value_is(0, CNT_MIN);
    src.pulse(0, 1'b0, N, N);
    value_is(0, CNT_MAX);
    apb(1'b0, ad(0, REG_STATUS), 32'h0);
    check_word(rd & 32'h3, 32'h3, "both flags");
    check_word(32'(irq_cnt), 32'h2, "irq pulses");
    apb(1'b1, ad(0, REG_STATUS), 32'h00000100);
    apb(1'b0, ad(0, REG_STATUS), 32'h0);
    check_word(rd & 32'h3, 32'h0, "flags cleared");
    apb(1'b1, ad(0, REG_CTRL), 32'h0);
    $display("test continuous done");
    apb(1'b1, ad(0, REG_LOAD), CNT_MAX);
    apb(1'b1, ad(0, REG_CTRL), cw(MODE_PERIODIC, DIR_NONE, 1'b1, 1'b1, 1'b0, FSEL_1K));
    apb(1'b1, ad(0, REG_LOAD), 32'h10);
    src.pulse(0, 1'b1, N, N);
    value_is(0, 32'h10);
    apb(1'b0, ad(0, REG_STATUS), 32'h0);
    check_word(rd & 32'h3, 32'h1, "limit reload flag");
    apb(1'b1, ad(0, REG_CTRL), 32'h0);
    src.pulse(0, 1'b1, N, N);
    value_is(0, 32'h10);
    $display("test periodic done");
    apb(1'b1, ad(1, REG_LOAD), CNT_MAX);
    apb(1'b1, ad(1, REG_CTRL), cw(MODE_ONCE, DIR_NONE, 1'b0, 1'b1, 1'b0, FSEL_1K));
    repeat (3) src.pulse(1, 1'b1, N, N);
    value_is(1, CNT_MIN);
    apb(1'b0, ad(1, REG_STATUS), 32'h0);
    check_bit(rd[ST_CLOSED_BIT], 1'b1, "auto closed");
    apb(1'b1, ad(1, REG_CTRL), cw(MODE_ONCE, DIR_NONE, 1'b0, 1'b0, 1'b0, FSEL_1K));
    apb(1'b1, ad(1, REG_CTRL), cw(MODE_ONCE, DIR_NONE, 1'b0, 1'b1, 1'b0, FSEL_1K));
    src.pulse(1, 1'b1, N, N);
    value_is(1, CNT_MIN + 1);
    $display("test count once done");
    irq_end_cnt = 0;
    for (int i = 0; i < 4; i++) begin
      up = (i % 2 == 0);
      m = (i < 2) ? MODE_ONCE : MODE_PERIODIC;
      apb(1'b1, ad(2, REG_CTRL), 32'h0);
      apb(1'b1, ad(2, REG_LOAD), 32'h5);
      apb(1'b1, ad(2, REG_END), up ? 32'h7 : 32'h3);
      apb(1'b1, ad(2, REG_CTRL),
          cw(m, up ? DIR_FWD : DIR_BWD, 1'b1, 1'b1, 1'b0, FSEL_1K) | 32'h00008000);
      repeat (3) src.pulse(2, up, N, N);
      value_is(2, (m == MODE_ONCE) ? 32'h5 : (up ? 32'h6 : 32'h4));
      apb(1'b0, ad(2, REG_STATUS), 32'h0);
      check_bit(rd[ST_CLOSED_BIT], m == MODE_ONCE, "end close");
    end
    check_word(32'(irq_end_cnt), 32'h2, "end irq pulses");
    apb(1'b1, ad(2, REG_LOAD), 32'h9);
    apb(1'b1, ad(2, REG_CTRL), 32'h00010000);
    value_is(2, 32'h9);
    $display("test end value done");
    apb(1'b1, ad(3, REG_LOAD), 32'h20);
    apb(1'b1, ad(3, REG_CTRL), cw(MODE_CONT, DIR_NONE, 1'b1, 1'b1, 1'b0, FSEL_1K));
    src.pulse(3, 1'b1, N, N);
    value_is(3, 32'h21);
    apb(1'b1, ad(3, REG_CTRL), cw(MODE_CONT, DIR_NONE, 1'b1, 1'b0, 1'b1, FSEL_1K));
    apb(1'b1, ad(3, REG_CTRL), cw(MODE_CONT, DIR_NONE, 1'b1, 1'b1, 1'b1, FSEL_1K));
    src.pulse(3, 1'b1, N, N);
    value_is(3, 32'h21);
    apb(1'b1, ad(3, REG_LOAD), 32'h40);
    src.drive(8, 1'b1, N + 4);
    src.pulse(3, 1'b1, N, N);
    value_is(3, 32'h41);
    src.drive(9, 1'b1, N);
    src.drive(9, 1'b0, N + 4);
    apb(1'b0, REG_LATCH, 32'h0);
    check_word(rd, 32'h41, "latched value");
    $display("test gate and latch done");
    report_and_stop();
  end
endmodule
